/* hw/adc_serial_conversion_port.sv */
// Purpose: serial command/result port and digital conversion core of the converter
// Assumes: analog levels arrive as ref_clk-domain unsigned magnitudes
// Notes: serial logic runs on the host clock; conversion runs on ref_clk
`include "adc_port_defines.svh"
`default_nettype none

module adc_serial_conversion_port
    import adc_port_pkg::*;
(
    // core clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // serial link from the host
    input wire logic serial_clk,
    input wire logic select_and_sleep_pin,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_en,
    // analog front end levels, ref_clk domain
    input wire logic [`LEVEL_W-1:0] analog_input_channels [`N_CHANNELS],
    input wire logic [`LEVEL_W-1:0] reference_level,
    // status
    output logic sleep_control
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------

    // positive input of a command: channel itself, or the chosen half of a pair
    function automatic logic [`CHAN_W-1:0] pos_chan(input logic mode,
                                                    input logic [`CHAN_W-1:0] chan);
        pos_chan = (mode == `MODE_SINGLE) ? chan : {chan[2:1], chan[0]};
    endfunction

    // negative input of a differential pair is the other half of it
    function automatic logic [`CHAN_W-1:0] neg_chan(input logic [`CHAN_W-1:0] chan);
        neg_chan = {chan[2:1], ~chan[0]};
    endfunction

    // bit of the result for a falling edge count, zero outside the frame
    function automatic logic out_bit(input logic [`RESULT_BITS-1:0] word,
                                     input logic [`CNT_W-1:0] cnt);
        logic [`CNT_W-1:0] idx;
        out_bit = 1'b0;
        idx = `CNT_ZERO;
        if (cnt >= `CNT_MSB && cnt <= `CNT_LSB) begin
            idx = `CNT_LSB - cnt; // msb first
            out_bit = word[idx[3:0]];
        end else if (cnt > `CNT_LSB && cnt <= `CNT_REV_END) begin
            idx = cnt - `CNT_LSB; // lsb already sent, resend from bit 1
            out_bit = word[idx[3:0]];
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    link_rise_t rise;
    link_rise_t next_rise;
    link_fall_t fall;
    link_fall_t next_fall;
    link_xfer_t xfer;
    link_xfer_t next_xfer;
    conv_t conv;
    conv_t next_conv;

    logic link_rst;
    logic cmd_done_edge;

    // select high is the session reset: aborts and clears the rise and fall state
    assign link_rst = sys_rst | select_and_sleep_pin;

    // edge at which the last channel bit is taken and the window opens
    assign cmd_done_edge = (rise.phase == PH_COMMAND) && (rise.cnt == `CNT_CH_MID);

    // ----------------------------------------------------------------
    // session decode on rising serial clock
    // ----------------------------------------------------------------

    // start hunt, command shift and bit position count
    always_comb begin
        next_rise = rise;
        unique case (rise.phase)
            PH_HUNT: begin
                // zeros before the start bit are skipped
                if (serial_data_in) begin
                    next_rise.phase = PH_COMMAND;
                    next_rise.cnt = `CNT_ZERO;
                end
            end
            PH_COMMAND: begin
                next_rise.cnt = rise.cnt + `CNT_ONE;
                unique case (next_rise.cnt)
                    `CNT_MODE: next_rise.mode = serial_data_in;
                    `CNT_CH_HIGH: next_rise.chan[2] = serial_data_in;
                    `CNT_CH_MID: next_rise.chan[1] = serial_data_in;
                    default: begin
                        next_rise.chan[0] = serial_data_in;
                        next_rise.phase = PH_CONVERT; // window opens here
                    end
                endcase
            end
            PH_CONVERT: begin
                // count saturates: past the reversed word only zeros go out
                if (rise.cnt != `CNT_MAX) begin
                    next_rise.cnt = rise.cnt + `CNT_ONE;
                end
                // the fifth clock is a don't care on the input
                if (next_rise.cnt == `CNT_CAPTURE) begin
                    // a result that is not back in time reads as zero
                    next_rise.word = (xfer.done_s2 == xfer.req) ? conv.result
                                                                : `CODE_ZERO;
                end
            end
            default: begin
                next_rise.phase = PH_HUNT;
            end
        endcase
    end

    always_ff @(posedge serial_clk or posedge link_rst) begin
        if (link_rst) begin
            rise <= '0;
        end else begin
            rise <= next_rise;
        end
    end

    // ----------------------------------------------------------------
    // request/done toggles on rising serial clock
    // ----------------------------------------------------------------

    // only the core reset clears these, so a dropped select never
    // leaves the two toggle copies out of step
    always_comb begin
        next_xfer = xfer;
        next_xfer.req = xfer.req ^ cmd_done_edge; // command held stable from here
        next_xfer.done_s1 = conv.done;
        next_xfer.done_s2 = xfer.done_s1;
    end

    always_ff @(posedge serial_clk or posedge sys_rst) begin
        if (sys_rst) begin
            xfer <= '0;
        end else begin
            xfer <= next_xfer;
        end
    end

    // ----------------------------------------------------------------
    // output stage on falling serial clock
    // ----------------------------------------------------------------

    // null bit then data; the driver stays off until the null bit
    always_comb begin
        next_fall = fall;
        if (rise.phase == PH_CONVERT) begin
            if (rise.cnt == `CNT_NULL) begin
                next_fall.oe = 1'b1;
                next_fall.dout = `NULL_BIT;
            end else if (rise.cnt > `CNT_NULL) begin
                next_fall.dout = out_bit(rise.word, rise.cnt);
            end
        end
    end

    // falling edges only move the output
    always_ff @(negedge serial_clk or posedge link_rst) begin
        if (link_rst) begin
            fall <= '0; // released at once on deselect
        end else begin
            fall <= next_fall;
        end
    end

    assign serial_data_out = fall.dout;
    assign serial_data_out_en = fall.oe;

    // ----------------------------------------------------------------
    // conversion core on ref_clk
    // ----------------------------------------------------------------
    logic [`LEVEL_W-1:0] pos_level;
    logic [`LEVEL_W-1:0] neg_level;
    logic [`LEVEL_W-1:0] diff_level;
    logic [`LEVEL_W+`FULL_SCALE_SHIFT-1:0] scaled;
    logic [`LEVEL_W+`FULL_SCALE_SHIFT-1:0] quotient;
    logic [`RESULT_BITS-1:0] code;

    // ideal transfer with clamps at both ends of the range
    always_comb begin
        pos_level = analog_input_channels[pos_chan(rise.mode, rise.chan)];
        neg_level = (rise.mode == `MODE_SINGLE) ? '0 : analog_input_channels[neg_chan(rise.chan)];
        // positive at or below negative gives all zeros
        diff_level = (pos_level > neg_level) ? (pos_level - neg_level) : '0;
        scaled = {diff_level, {`FULL_SCALE_SHIFT{1'b0}}}; // times 4096
        quotient = (reference_level != '0) ? (scaled / {{`FULL_SCALE_SHIFT{1'b0}},
                                                        reference_level}) : '1;
        // full scale less one step and above reads all ones
        if (quotient > {{`LEVEL_W{1'b0}}, `CODE_MAX}) begin
            code = `CODE_MAX;
        end else begin
            code = quotient[`RESULT_BITS-1:0];
        end
    end

    // request sync, sample hold, done toggle and standby flag
    always_comb begin
        next_conv = conv;
        next_conv.req_s1 = xfer.req;
        next_conv.req_s2 = conv.req_s1;
        next_conv.sel_s1 = select_and_sleep_pin;
        next_conv.sel_s2 = conv.sel_s1;
        next_conv.standby = conv.sel_s2; // low power flag while deselected
        // the command is stable once the toggle is seen; hold the sample
        if (conv.req_s2 != conv.req_seen) begin
            next_conv.req_seen = conv.req_s2;
            next_conv.result = code; // twelve bit held result
            next_conv.done = ~conv.done;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv <= '0;
        end else begin
            conv <= next_conv;
        end
    end

    assign sleep_control = conv.standby;

endmodule

`default_nettype wire

/* common/adc_port_defines.svh */
// Purpose: constants of the serial conversion port (bit positions, counts, codes)
// Assumes: serial clock counts start at the start bit edge (count 0)
// Notes: included by the package and the port module
//
// What this block does
// - chip-select low opens a new session
// - chip-select high aborts conversion, enters standby
// - serial clock starts conversion, shifts result out
// - command bits come from serial data input
// - data output changes only on falling edges
// - sample window opens fourth rise, lasts 1.5
// - result is twelve bits, sent serially
// - single-ended mode gives eight channels 0-7
// - differential mode picks pair polarity from command
// - differential result zero when positive not above negative
// - differential result saturates at all ones
// - code equals input times 4096 over reference
// - first high data bit with select low starts
// - mode bit, three channel bits, one idle clock
// - null bit, then twelve bits MSB first
// - extra clocks resend LSB first, then zeros
`ifndef ADC_PORT_DEFINES_SVH
`define ADC_PORT_DEFINES_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define RESULT_BITS 12
`define CNT_W 5
`define LEVEL_W 16
`define CHAN_W 3
`define N_CHANNELS 8
`define FULL_SCALE_SHIFT 12

// ----------------------------------------------------------------
// rising edge counts after the start bit
// ----------------------------------------------------------------
`define CNT_ZERO 5'h00
`define CNT_ONE 5'h01
`define CNT_MODE 5'h01
`define CNT_CH_HIGH 5'h02
`define CNT_CH_MID 5'h03
`define CNT_CH_LOW 5'h04
`define CNT_WINDOW_CLOSE 5'h05
`define CNT_NULL 5'h06
`define CNT_CAPTURE 5'h07
`define CNT_MSB 5'h07
`define CNT_LSB 5'h12
`define CNT_REV_END 5'h1d
`define CNT_MAX 5'h1f

// ----------------------------------------------------------------
// codes
// ----------------------------------------------------------------
`define CODE_ZERO 12'h000
`define CODE_MAX 12'hfff
`define MODE_SINGLE 1'b1
`define NULL_BIT 1'b0

`endif

/* common/adc_port_pkg.sv */
// Purpose: types for the serial conversion port
// Assumes: constants come from adc_port_defines.svh
// Notes: one struct per clocked group of state
`include "adc_port_defines.svh"
`default_nettype none

package adc_port_pkg;

    // ----------------------------------------------------------------
    // serial session phases, gray along hunt -> command -> convert
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_HUNT = 2'b00,
        PH_COMMAND = 2'b01,
        PH_CONVERT = 2'b11
    } link_phase_t;

    // session state on rising serial clock, cleared by select high
    typedef struct packed {
        link_phase_t phase;
        logic [`CNT_W-1:0] cnt;
        logic mode;
        logic [`CHAN_W-1:0] chan;
        logic [`RESULT_BITS-1:0] word;
    } link_rise_t;

    // output stage on falling serial clock
    typedef struct packed {
        logic dout;
        logic oe;
    } link_fall_t;

    // crossing state on rising serial clock, survives select high
    typedef struct packed {
        logic req;
        logic done_s1;
        logic done_s2;
    } link_xfer_t;

    // converter side state on ref_clk
    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic done;
        logic [`RESULT_BITS-1:0] result;
        logic sel_s1;
        logic sel_s2;
        logic standby;
    } conv_t;

endpackage

`default_nettype wire

/* tb/adc_port_sva.sv */
// Purpose: pin-level checks of the serial conversion port
// Assumes: host holds serial_clk still outside frames
// Notes: bound from the bench top
`include "adc_port_defines.svh"
`default_nettype none
module adc_port_sva
    import adc_port_pkg::*;
(
    // clocks and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic serial_clk,
    // link pins
    input wire logic select_and_sleep_pin,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_out_en,
    // status
    input wire logic sleep_control
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // rise counter since the start bit
    // ----------------------------------------
    logic started;
    logic [`CNT_W-1:0] hc;
    // cleared by select high, like the session it mirrors
    always_ff @(posedge serial_clk or posedge select_and_sleep_pin or posedge sys_rst) begin
        if (sys_rst || select_and_sleep_pin) begin
            started <= 1'b0;
            hc <= `CNT_ZERO;
        end else if (!started) begin
            started <= serial_data_in;
        end else if (hc != `CNT_MAX) begin
            hc <= hc + `CNT_ONE;
        end
    end
    sequence s_deselect;
        $rose(select_and_sleep_pin);
    endsequence
    sequence s_select;
        $fell(select_and_sleep_pin);
    endsequence
    property p_oe_off;
        @(posedge ref_clk) disable iff (sys_rst) select_and_sleep_pin |-> !serial_data_out_en;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("enable while deselected");
    property p_sleep;
        @(posedge ref_clk) disable iff (sys_rst) s_deselect |-> ##[2:4] sleep_control;
    endproperty
    a_sleep: assert property (p_sleep) else $error("no standby");
    property p_wake;
        @(posedge ref_clk) disable iff (sys_rst) s_select |-> ##[2:4] !sleep_control;
    endproperty
    a_wake: assert property (p_wake) else $error("standby stuck");
    property p_dout_fall;
        @(posedge ref_clk) disable iff (sys_rst)
            (!select_and_sleep_pin && $past(!select_and_sleep_pin) && $changed(serial_data_out))
            |-> (!serial_clk && $past(serial_clk));
    endproperty
    a_dout_fall: assert property (p_dout_fall) else $error("data moved off a fall");
    property p_en_rise;
        @(posedge ref_clk) disable iff (sys_rst)
            $rose(serial_data_out_en) |-> (!serial_clk && !serial_data_out);
    endproperty
    a_en_rise: assert property (p_en_rise) else $error("bad enable start");
    property p_en_window;
        @(posedge serial_clk) disable iff (sys_rst || select_and_sleep_pin)
            started |-> (serial_data_out_en == (hc >= 5'h06));
    endproperty
    a_en_window: assert property (p_en_window) else $error("enable timing");
    property p_null;
        @(posedge serial_clk) disable iff (sys_rst || select_and_sleep_pin)
            (started && hc == `CNT_NULL) |-> !serial_data_out;
    endproperty
    a_null: assert property (p_null) else $error("null bit not low");
    property p_tail;
        @(posedge serial_clk) disable iff (sys_rst || select_and_sleep_pin)
            (started && hc >= 5'h1e) |-> !serial_data_out;
    endproperty
    a_tail: assert property (p_tail) else $error("tail not zero");
endmodule
`default_nettype wire

/* tb/host_master.sv */
// Purpose: behavioural host serial master
// Assumes: one frame per go pulse, the start bit rise then 31 more rises
// Notes: clock stands still low between frames
`default_nettype none
module host_master
(
    // bench side
    input wire logic ref_clk,
    input wire logic go,
    input wire logic mode,
    input wire logic [2:0] chan,
    input wire logic [2:0] lead,
    input wire logic [5:0] abort_at,
    output logic busy,
    output logic [31:0] rx,
    output logic [31:0] rx_en,
    // serial pins
    output logic serial_clk,
    output logic select_and_sleep_pin,
    output logic serial_data_in,
    input wire logic serial_data_out,
    input wire logic serial_data_out_en
);
    timeunit 1ns;
    timeprecision 1ps;
    int k;
    initial begin
        busy = 1'b0;
        serial_clk = 1'b0;
        select_and_sleep_pin = 1'b1;
        serial_data_in = 1'b0;
        rx = 32'h0;
        rx_en = 32'h0;
    end
    // 32 ns period keeps the clock far above the droop limit
    always @(posedge ref_clk) begin
        if (go) begin
            busy = 1'b1;
            rx = 32'h0;
            rx_en = 32'h0;
            #1;
            select_and_sleep_pin = 1'b0;
            #100;
            for (k = 0 - int'(lead); k < 32; k++) begin
                if (k < 0) begin
                    serial_data_in = 1'b0;
                end else if (k == 0) begin
                    serial_data_in = 1'b1;
                end else if (k == 1) begin
                    serial_data_in = mode;
                end else if (k < 5) begin
                    serial_data_in = chan[4 - k];
                end else begin
                    serial_data_in = ~serial_data_in; // don't-care bits never rest
                end
                #8;
                serial_clk = 1'b1;
                if (k >= 0) begin
                    // a released line shows the inverse of its last level
                    rx[k] = serial_data_out_en ? serial_data_out : ~serial_data_out;
                    rx_en[k] = serial_data_out_en;
                end
                #16;
                serial_clk = 1'b0;
                #8;
                if (abort_at != 6'h00 && k == int'(abort_at)) begin
                    break;
                end
            end
            select_and_sleep_pin = 1'b1;
            serial_data_in = ~serial_data_in;
            #500;
            busy = 1'b0;
        end
    end
endmodule
`default_nettype wire

/* tb/adc_serial_conversion_port_tb_top.sv */
// Purpose: self-checking bench of the serial conversion port
// Assumes: reference 2000h unless a scenario changes it
// Notes: expected codes use the ideal transfer with saturation
`include "adc_port_defines.svh"
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) begin \
            fail_count++; \
            $display("BAD %s exp %h got %h", nm, e, g); \
        end \
    end
module adc_serial_conversion_port_tb_top
    import adc_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, sys_rst, go, mode, serial_clk, sel, din, dout, oe, sleep, busy;
    logic [2:0] chan, lead;
    logic [5:0] abort_at;
    logic [31:0] rx, rx_en;
    logic [`LEVEL_W-1:0] lv [`N_CHANNELS];
    logic [`LEVEL_W-1:0] ref_lvl;
    int fail_count = 0;
    int n_tests = 0;
    adc_serial_conversion_port u_adc_serial_conversion_port (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .serial_clk(serial_clk), .select_and_sleep_pin(sel),
        .serial_data_in(din), .serial_data_out(dout), .serial_data_out_en(oe),
        .analog_input_channels(lv), .reference_level(ref_lvl), .sleep_control(sleep));
    host_master u_host_master (.ref_clk(ref_clk), .go(go), .mode(mode), .chan(chan),
        .lead(lead), .abort_at(abort_at), .busy(busy), .rx(rx), .rx_en(rx_en),
        .serial_clk(serial_clk), .select_and_sleep_pin(sel), .serial_data_in(din),
        .serial_data_out(dout), .serial_data_out_en(oe));
    function automatic logic [11:0] exp_code(input int pos, input int neg, input int rf);
        int v;
        v = (pos <= neg) ? 0 : (pos - neg) * 4096 / rf;
        return (v > 4095) ? 12'hfff : v[11:0];
    endfunction
    function automatic logic [31:0] frame_of(input logic [11:0] code);
        logic [31:0] f;
        f = 32'h0;
        for (int i = 0; i < 12; i++) begin
            f[19 - i] = code[i];
            f[19 + i] = (i > 0) ? code[i] : f[19];
        end
        return f;
    endfunction
    task automatic frame(input logic m, input logic [2:0] c, input logic [2:0] ld,
                         input logic [5:0] ab);
        int w;
        mode <= m;
        chan <= c;
        lead <= ld;
        abort_at <= ab;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        w = 0;
        @(posedge ref_clk);
        while (busy !== 1'b0 && w < 2000) begin
            @(posedge ref_clk);
            w++;
        end
        `CHK("frame done", 1'b1, w < 2000)
    endtask
    task automatic check_frame(input logic [11:0] code);
        `CHK("enable", 32'hffffff80, rx_en)
        `CHK("frame", frame_of(code), rx & 32'hffffff80)
    endtask
    task automatic t_single();
        for (int c = 0; c < 8; c++) begin
            frame(1'b1, c[2:0], c[2:0], 6'h00);
            check_frame(exp_code(lv[c], 0, ref_lvl));
        end
    endtask
    task automatic t_diff();
        int ev;
        for (int r = 0; r < 2; r++) begin
            ref_lvl <= r ? 16'h0400 : 16'h2000;
            for (int c = 0; c < 8; c++) begin
                ev = c & 6;
                frame(1'b0, c[2:0], 3'h0, 6'h00);
                if (c[0]) begin
                    check_frame(exp_code(lv[ev + 1], lv[ev], ref_lvl));
                end else begin
                    check_frame(exp_code(lv[ev], lv[ev + 1], ref_lvl));
                end
            end
        end
        ref_lvl <= 16'h2000;
    endtask
    task automatic t_abort();
        frame(1'b1, 3'h5, 3'h2, 6'h0a);
        `CHK("abort enable", 32'h00000780, rx_en)
        `CHK("abort oe", 1'b0, oe)
        `CHK("standby", 1'b1, sleep)
        frame(1'b1, 3'h5, 3'h0, 6'h00);
        check_frame(exp_code(lv[5], 0, ref_lvl));
    endtask
    // input moves after the window closes but before the word is latched
    task automatic t_hold();
        logic [11:0] held;
        held = exp_code(lv[3], 0, ref_lvl);
        fork
            frame(1'b1, 3'h3, 3'h0, 6'h00);
            begin
                // lands between the fall after rise 5 and rise 7
                repeat (73) @(posedge ref_clk);
                lv[3] <= 16'h0000;
            end
        join
        check_frame(held);
        lv[3] <= 16'h0123 + 16'h0003 * 16'h0911;
    endtask
    task automatic summarize();
        $display("tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // 250 MHz core clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // main sequence
    initial begin
        sys_rst = 1'b1;
        {go, mode, chan, lead, abort_at} = '0;
        ref_lvl = 16'h2000;
        for (int i = 0; i < 8; i++) begin
            lv[i] = 16'h0123 + 16'(i) * 16'h0911;
        end
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        `CHK("reset standby", 1'b1, sleep)
        `CHK("reset oe", 1'b0, oe)
        t_single();
        t_diff();
        t_abort();
        t_hold();
        summarize();
    end
    // hang guard, about four and a half times the expected run
    initial begin
        #200000;
        fail_count++;
        summarize();
    end
endmodule
bind adc_serial_conversion_port adc_port_sva u_adc_port_sva (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .serial_clk(serial_clk), .select_and_sleep_pin(select_and_sleep_pin),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_out_en(serial_data_out_en), .sleep_control(sleep_control));
`default_nettype wire
